/* rtl/urxtf_params.svh */
`ifndef URXTF_PARAMS_SVH
`define URXTF_PARAMS_SVH
// register byte offsets
`define URXTF_ADR_MODE0 8'h00
`define URXTF_ADR_MODE1 8'h04
`define URXTF_ADR_MODE2 8'h08
`define URXTF_ADR_STATUS 8'h0C
`define URXTF_ADR_CMD 8'h10
`define URXTF_ADR_RXQ 8'h14
`define URXTF_ADR_ISR 8'h18
`define URXTF_ADR_IMR 8'h1C
`define URXTF_ADR_PRE_HI 8'h20
`define URXTF_ADR_PRE_LO 8'h24
`define URXTF_ADR_OPSET 8'h28
`define URXTF_ADR_OPCLR 8'h2C
`define URXTF_ADR_OPLATCH 8'h30
`define URXTF_ADR_TXQ 8'h34
// field positions
`define URXTF_MODE0_WDOG 7
`define URXTF_MODE1_RTSCTL 7
`define URXTF_MODE1_TAG 2
`define URXTF_MODE2_CTSEN 4
`define URXTF_ISR_CTRDY 3
`define URXTF_ISR_WDOG 4
`define URXTF_ST_PAR 5
`define URXTF_ST_FRAME 6
`define URXTF_ST_BREAK 7
`define URXTF_ST_OVR 4
`define URXTF_ST_FULL 1
`define URXTF_ST_RDY 0
// command codes
`define URXTF_CMD_RX_EN 2'b01
`define URXTF_CMD_RX_DIS 2'b10
`define URXTF_CMD_RST_RX 4'h2
`define URXTF_CMD_RST_ERR 4'h4
`define URXTF_CMD_RTS_ON 4'h8
`define URXTF_CMD_RTS_OFF 4'h9
`define URXTF_CMD_TMO_ON 4'hA
`define URXTF_CMD_TMO_OFF 4'hC
`define URXTF_PARITY_MULTIDROP 2'b11
// timing
`define URXTF_WDOG_BITS 64
`define URXTF_RESET_MODE1 8'h00
`endif

/* rtl/urxtf_pkg.sv */
package urxtf_pkg;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_DATA = 3'b010,
        RX_STOP = 3'b100
    } urxtf_rx_type;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SHIFT = 3'b010,
        TX_DONE = 3'b100
    } urxtf_tx_type;
endpackage

/* rtl/urxtf_channel.sv */
// Notes on behaviour
// - disable drops partial character outside multidrop, queue kept
// - receiver reset clears state, rts and watchdog flags, pointers
// - idle watchdog interrupt enabled by mode0 bit7
// - watchdog 64 bits, restarted by push/read
// - timeout mode: each push restarts counter
// - command A enables, C disables timeout
// - both channels: timeout needs both idle
// - timeout mode ignores counter start/stop
// - push stops one tick, reloads, restarts
// - timeout sets isr bit3, imr bit3 interrupts
// - new character clears counter-ready flag
// - timeout-enable clears flag, holds counter
// - cts enable makes transmitter obey cts
// - full queue plus start raises rts
// - mode1 bit7 hands pin to receiver
// - commands 8 and 9 drive rts
// - pin is nand of latch and request
// - parity field 11 selects multidrop
// - multidrop frame carries tag from mode1
// - disabled receiver keeps only address chars
// - tag stored in parity status bit5
//
// Design decisions made here: the Wishbone register port and the address map.
`include "urxtf_params.svh"
module urxtf_channel #(
    parameter int DEPTH = 8,
    parameter int BIT_CYCLES = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial line
    input wire logic rxLine,
    output logic txLine,
    input wire logic txClearInputN,
    output logic rxRequestOutputN,
    // other channel timeout mode and idle state
    input wire logic peerTimeoutIdle,
    output logic timeoutIdle,
    // counter tick and interrupt
    input wire logic counterTick,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int BW = $clog2(BIT_CYCLES * `URXTF_WDOG_BITS + 1);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] mode0, mode1, mode2, interrupt_mask_register, preHi, preLo;
        logic opLatch, rtsCmd, rxEn, tmoMode, ctRdy, ctRun, ctReload, wdogFlag;
        logic overrun, rtsFull;
        logic [15:0] counter;
        logic [BW-1:0] wdog;
        urxtf_pkg::urxtf_rx_type rxState;
        logic [7:0] rxCnt;
        logic [3:0] rxBit;
        logic [8:0] rxShift;
        logic [DEPTH-1:0][10:0] qData;
        logic [PW:0] wp, rp;
        urxtf_pkg::urxtf_tx_type txState;
        logic [7:0] txCnt;
        logic [3:0] txBit;
        logic [9:0] txShift;
        logic [7:0] txHold;
        logic txPend, txOut;
    } urxtf_state_type;
    urxtf_state_type s, next_s;
    // release copy of reset, kept apart as it has its own asynchronous reset
    logic [1:0] rstSync;
    logic rstSafe;
    assign rstSafe = rstSync[1];
    function automatic logic [PW:0] qCount(input logic [PW:0] w, input logic [PW:0] r);
        return w - r;
    endfunction
    logic multidrop, qFull, qEmpty, access, push, pop, started;
    logic [3:0] cmdHi;
    always_comb begin
        next_s = s;
        multidrop = s.mode1[4:3] == `URXTF_PARITY_MULTIDROP;
        qFull = qCount(s.wp, s.rp) == (PW+1)'(DEPTH);
        qEmpty = s.wp == s.rp;
        access = wb_cyc_i && wb_stb_i && !s.ack;
        next_s.ack = access;
        pop = access && !wb_we_i && wb_adr_i == `URXTF_ADR_RXQ && !qEmpty;
        push = 1'b0;
        started = 1'b0;
        cmdHi = wb_dat_i[7:4];
        // receiver
        case (s.rxState)
            urxtf_pkg::RX_IDLE: begin
                if (!rxLine && (s.rxEn || multidrop)) begin
                    next_s.rxState = urxtf_pkg::RX_DATA;
                    next_s.rxCnt = 8'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
                    next_s.rxBit = 4'h0;
                    started = 1'b1;
                end
            end
            urxtf_pkg::RX_DATA: begin
                if (s.rxCnt == 8'h00) begin
                    next_s.rxShift = {rxLine, s.rxShift[8:1]};
                    next_s.rxCnt = 8'(BIT_CYCLES - 1);
                    next_s.rxBit = s.rxBit + 4'h1;
                    if (s.rxBit == (multidrop ? 4'h8 : 4'h7))
                        next_s.rxState = urxtf_pkg::RX_STOP;
                end else begin
                    next_s.rxCnt = s.rxCnt - 8'h01;
                end
            end
            urxtf_pkg::RX_STOP: begin
                if (s.rxCnt == 8'h00) begin
                    next_s.rxState = urxtf_pkg::RX_IDLE;
                    if (!multidrop || s.rxEn || s.rxShift[8])
                        push = 1'b1;
                end else begin
                    next_s.rxCnt = s.rxCnt - 8'h01;
                end
            end
            default: next_s.rxState = urxtf_pkg::RX_IDLE;
        endcase
        if (started && qFull && s.mode1[`URXTF_MODE1_RTSCTL])
            next_s.rtsFull = 1'b1;
        if (!qFull)
            next_s.rtsFull = 1'b0;
        if (push) begin
            if (qFull && !pop) begin
                next_s.overrun = 1'b1;
            end else begin
                // tag into parity slot, framing and break as usual
                next_s.qData[s.wp[PW-1:0]] = {
                    !rxLine && (multidrop ? s.rxShift[7:0] : s.rxShift[8:1]) == 8'h00,
                    !rxLine,
                    multidrop ? s.rxShift[8] : 1'b0,
                    multidrop ? s.rxShift[7:0] : s.rxShift[8:1]};
                next_s.wp = s.wp + (PW+1)'(1);
            end
        end
        if (pop)
            next_s.rp = s.rp + (PW+1)'(1);
        // watchdog; isr read clears the flag, an expiry in the same cycle wins
        if (access && !wb_we_i && wb_adr_i == `URXTF_ADR_ISR)
            next_s.wdogFlag = 1'b0;
        if (push || pop) begin
            next_s.wdog = '0;
        end else if (s.wdog != BW'(BIT_CYCLES * `URXTF_WDOG_BITS)) begin
            next_s.wdog = s.wdog + BW'(1);
            if (s.wdog == BW'(BIT_CYCLES * `URXTF_WDOG_BITS - 1) && !qEmpty)
                next_s.wdogFlag = 1'b1;
        end
        // shared counter in timeout mode
        if (s.tmoMode && counterTick) begin
            if (s.ctReload) begin
                next_s.counter = {s.preHi, s.preLo};
                next_s.ctReload = 1'b0;
                next_s.ctRun = 1'b1;
            end else if (s.ctRun) begin
                if (s.counter == 16'h0000) begin
                    // wait at zero until the other channel is idle too
                    if (peerTimeoutIdle) begin
                        next_s.ctRun = 1'b0;
                        next_s.ctRdy = 1'b1;
                    end
                end else begin
                    next_s.counter = s.counter - 16'h0001;
                end
            end
        end
        if (push && s.tmoMode) begin
            next_s.ctRun = 1'b0;
            next_s.ctReload = 1'b1;
            next_s.ctRdy = 1'b0;
        end
        // transmitter
        case (s.txState)
            urxtf_pkg::TX_IDLE: begin
                next_s.txOut = 1'b1;
                if (s.txPend && !(s.mode2[`URXTF_MODE2_CTSEN] && txClearInputN)) begin
                    next_s.txShift = multidrop
                        ? {s.mode1[`URXTF_MODE1_TAG], s.txHold, 1'b0}
                        : {1'b1, s.txHold, 1'b0};
                    next_s.txPend = 1'b0;
                    next_s.txBit = multidrop ? 4'hA : 4'h9;
                    next_s.txCnt = 8'(BIT_CYCLES - 1);
                    next_s.txState = urxtf_pkg::TX_SHIFT;
                end
            end
            urxtf_pkg::TX_SHIFT: begin
                next_s.txOut = s.txShift[0];
                if (s.txCnt == 8'h00) begin
                    next_s.txCnt = 8'(BIT_CYCLES - 1);
                    next_s.txShift = {1'b1, s.txShift[9:1]};
                    next_s.txBit = s.txBit - 4'h1;
                    if (s.txBit == 4'h0)
                        next_s.txState = urxtf_pkg::TX_DONE;
                end else begin
                    next_s.txCnt = s.txCnt - 8'h01;
                end
            end
            urxtf_pkg::TX_DONE: next_s.txState = urxtf_pkg::TX_IDLE;
            default: next_s.txState = urxtf_pkg::TX_IDLE;
        endcase
        // register writes
        if (access && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `URXTF_ADR_MODE0)
                next_s.mode0 = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_MODE1)
                next_s.mode1 = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_MODE2)
                next_s.mode2 = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_IMR)
                next_s.interrupt_mask_register = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_PRE_HI)
                next_s.preHi = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_PRE_LO)
                next_s.preLo = wb_dat_i[7:0];
            else if (wb_adr_i == `URXTF_ADR_OPSET && wb_dat_i[0])
                next_s.opLatch = 1'b1;
            else if (wb_adr_i == `URXTF_ADR_OPCLR && wb_dat_i[0])
                next_s.opLatch = 1'b0;
            else if (wb_adr_i == `URXTF_ADR_TXQ && !s.txPend) begin
                next_s.txHold = wb_dat_i[7:0];
                next_s.txPend = 1'b1;
            end else if (wb_adr_i == `URXTF_ADR_CMD) begin
                if (wb_dat_i[1:0] == `URXTF_CMD_RX_EN)
                    next_s.rxEn = 1'b1;
                if (wb_dat_i[1:0] == `URXTF_CMD_RX_DIS) begin
                    next_s.rxEn = 1'b0;
                    if (!multidrop)
                        next_s.rxState = urxtf_pkg::RX_IDLE;
                end
                if (cmdHi == `URXTF_CMD_RST_RX) begin
                    next_s.rxEn = 1'b0;
                    next_s.rxState = urxtf_pkg::RX_IDLE;
                    next_s.wp = '0;
                    next_s.rp = '0;
                    next_s.qData[0] = '0;
                    next_s.rtsFull = 1'b0;
                    next_s.wdogFlag = 1'b0;
                end
                if (cmdHi == `URXTF_CMD_RST_ERR)
                    next_s.overrun = 1'b0;
                if (cmdHi == `URXTF_CMD_RTS_ON)
                    next_s.rtsCmd = 1'b1;
                if (cmdHi == `URXTF_CMD_RTS_OFF)
                    next_s.rtsCmd = 1'b0;
                if (cmdHi == `URXTF_CMD_TMO_ON) begin
                    next_s.tmoMode = 1'b1;
                    next_s.ctRdy = 1'b0;
                    next_s.ctRun = 1'b0;
                    next_s.ctReload = 1'b0;
                end
                if (cmdHi == `URXTF_CMD_TMO_OFF)
                    next_s.tmoMode = 1'b0;
            end
        end
        // read data
        next_s.rdata = 32'h0000_0000;
        if (access && !wb_we_i) begin
            if (wb_adr_i == `URXTF_ADR_MODE0)
                next_s.rdata[7:0] = s.mode0;
            else if (wb_adr_i == `URXTF_ADR_MODE1)
                next_s.rdata[7:0] = s.mode1;
            else if (wb_adr_i == `URXTF_ADR_MODE2)
                next_s.rdata[7:0] = s.mode2;
            else if (wb_adr_i == `URXTF_ADR_STATUS)
                next_s.rdata[7:0] = {s.qData[s.rp[PW-1:0]][10:8] & {3{!qEmpty}},
                    s.overrun, 2'b00, qFull, !qEmpty};
            else if (wb_adr_i == `URXTF_ADR_RXQ)
                next_s.rdata[7:0] = s.qData[s.rp[PW-1:0]][7:0];
            else if (wb_adr_i == `URXTF_ADR_ISR)
                next_s.rdata[7:0] = {3'b000, s.wdogFlag, s.ctRdy, 3'b000};
            else if (wb_adr_i == `URXTF_ADR_IMR)
                next_s.rdata[7:0] = s.interrupt_mask_register;
            else if (wb_adr_i == `URXTF_ADR_PRE_HI)
                next_s.rdata[7:0] = s.counter[15:8];
            else if (wb_adr_i == `URXTF_ADR_PRE_LO)
                next_s.rdata[7:0] = s.counter[7:0];
            else if (wb_adr_i == `URXTF_ADR_OPLATCH)
                next_s.rdata[1:0] = {s.tmoMode, s.opLatch};
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    always_ff @(posedge ref_clk or negedge rstSafe) begin
        if (!rstSafe) begin
            s.ack <= 1'b0;
            s.rdata <= '0;
            s.mode0 <= 8'h00;
            s.mode1 <= `URXTF_RESET_MODE1;
            s.mode2 <= 8'h00;
            s.interrupt_mask_register <= 8'h00;
            s.preHi <= 8'h00;
            s.preLo <= 8'h00;
            s.opLatch <= 1'b0;
            s.rtsCmd <= 1'b0;
            s.rxEn <= 1'b0;
            s.tmoMode <= 1'b0;
            s.ctRdy <= 1'b0;
            s.ctRun <= 1'b0;
            s.ctReload <= 1'b0;
            s.wdogFlag <= 1'b0;
            s.overrun <= 1'b0;
            s.rtsFull <= 1'b0;
            s.counter <= 16'h0000;
            s.wdog <= '0;
            s.rxState <= urxtf_pkg::RX_IDLE;
            s.rxCnt <= 8'h00;
            s.rxBit <= 4'h0;
            s.rxShift <= 9'h000;
            s.qData <= '0;
            s.wp <= '0;
            s.rp <= '0;
            s.txState <= urxtf_pkg::TX_IDLE;
            s.txCnt <= 8'h00;
            s.txBit <= 4'h0;
            s.txShift <= 10'h3FF;
            s.txHold <= 8'h00;
            s.txPend <= 1'b0;
            s.txOut <= 1'b1;
        end else begin
            {s.ack, s.rdata, s.mode0, s.mode1, s.mode2, s.interrupt_mask_register, s.preHi, s.preLo} <=
                {next_s.ack, next_s.rdata, next_s.mode0, next_s.mode1, next_s.mode2,
                 next_s.interrupt_mask_register, next_s.preHi, next_s.preLo};
            {s.opLatch, s.rtsCmd, s.rxEn, s.tmoMode, s.ctRdy, s.ctRun, s.ctReload} <=
                {next_s.opLatch, next_s.rtsCmd, next_s.rxEn, next_s.tmoMode,
                 next_s.ctRdy, next_s.ctRun, next_s.ctReload};
            {s.wdogFlag, s.overrun, s.rtsFull, s.counter, s.wdog} <=
                {next_s.wdogFlag, next_s.overrun, next_s.rtsFull, next_s.counter, next_s.wdog};
            {s.rxState, s.rxCnt, s.rxBit, s.rxShift, s.wp, s.rp} <=
                {next_s.rxState, next_s.rxCnt, next_s.rxBit, next_s.rxShift, next_s.wp, next_s.rp};
            s.qData <= next_s.qData;
            {s.txState, s.txCnt, s.txBit, s.txShift, s.txHold, s.txPend, s.txOut} <=
                {next_s.txState, next_s.txCnt, next_s.txBit, next_s.txShift,
                 next_s.txHold, next_s.txPend, next_s.txOut};
        end
    end
    // pin: nand of latch and receiver request; flow control leaves the latch alone
    // request comes from the receiver under flow control, else from the command
    assign rxRequestOutputN = !(s.opLatch && (s.mode1[`URXTF_MODE1_RTSCTL]
        ? !s.rtsFull : s.rtsCmd));
    assign txLine = s.txOut;
    assign timeoutIdle = !s.tmoMode || (s.ctRun && s.counter == 16'h0000)
        || (!s.ctRun && !s.ctReload);
    assign irq = (s.ctRdy && s.interrupt_mask_register[`URXTF_ISR_CTRDY])
        || (s.wdogFlag && s.mode0[`URXTF_MODE0_WDOG]);
    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
endmodule

/* verif/urxtf_channel_assertions.sv */
module urxtf_channel_checker #(
    parameter int BIT_CYCLES = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // serial
    input wire logic txLine,
    input wire logic rxRequestOutputN
);
    localparam int FRAME_LOW = 11 * BIT_CYCLES;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic txPrev;
    logic [15:0] bitAge;
    // edges since the serial output last changed, saturating
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            txPrev <= 1'b1;
            bitAge <= 16'h0000;
        end else begin
            txPrev <= txLine;
            bitAge <= (txLine != txPrev) ? 16'h0001 : bitAge + {15'h0000, bitAge != 16'hFFFF};
        end
    end
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_quiet;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_quiet: assert property (p_ack_quiet) else $error("ack while bus idle");
    property p_dat_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits not zero");
    property p_tx_bit;
        (txLine != txPrev) |-> bitAge >= 16'(BIT_CYCLES);
    endproperty
    a_tx_bit: assert property (p_tx_bit) else $error("serial bit shorter than a bit time");
    property p_tx_frame;
        $fell(txLine) |-> ##[1:FRAME_LOW] txLine;
    endproperty
    a_tx_frame: assert property (p_tx_frame) else $error("serial output low too long");
    property p_pin_fall;
        $fell(rxRequestOutputN) |-> $past(wb_cyc_i && wb_stb_i) || $past(wb_cyc_i && wb_stb_i, 2);
    endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("request pin fell without access");
endmodule
bind urxtf_channel urxtf_channel_checker #(.BIT_CYCLES(BIT_CYCLES)) u_urxtf_channel_checker (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txLine(txLine),
    .rxRequestOutputN(rxRequestOutputN));

/* verif/urxtf_peer.sv */
module urxtf_peer #(
    parameter int BIT = 4
) (
    // clock
    input wire logic ref_clk,
    // serial lines
    output logic rxLine,
    input wire logic txLine,
    output logic tx_clear_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic md = 1'b0;
    logic got = 1'b0;
    logic [8:0] gotData = 9'h000;
    initial begin
        rxLine = 1'b1;
        tx_clear_input_n = 1'b1;
    end
    // start, eight data bits lsb first, tag in multidrop, stop
    task automatic send(input logic [7:0] d, input logic tag);
        logic [10:0] f;
        f = md ? {1'b1, tag, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < (md ? 11 : 10); i++) begin
            rxLine <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
    endtask
    always begin
        @(negedge txLine);
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge ref_clk);
            gotData[i] <= txLine;
        end
        if (!md) gotData[8] <= 1'b0;
        got <= 1'b1;
        @(posedge ref_clk);
        got <= 1'b0;
    end
endmodule

/* verif/testbench.sv */
`include "urxtf_params.svh"
`define CHK(nm, ex, sn) \
    begin \
        cmpCount++; \
        if ((sn) !== (ex)) begin \
            nErrors++; \
            $display("ERROR %s expected %0h seen %0h", nm, ex, sn); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 4;
    logic refClk, resetN, wbCyc, wbStb, wbWe, wbAck, tick, pinN, irq, txLine, rxLine, tx_clear_input_n;
    logic peerIdle, tmoIdle;
    logic [7:0] wbAdr, d, e;
    logic [7:0] q[9];
    logic [31:0] wbDatW, wbDatR;
    logic [39:0] expQ[$];
    logic [8:0] txQ[$];
    logic [31:0] seed = 32'h26BA1607;
    int nErrors = 0;
    int cmpCount = 0;
    int n;
    urxtf_channel #(.DEPTH(8), .BIT_CYCLES(BITC)) u_urxtf_channel (
        .ref_clk(refClk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rxLine(rxLine), .txLine(txLine),
        .txClearInputN(tx_clear_input_n), .rxRequestOutputN(pinN), .peerTimeoutIdle(peerIdle),
        .timeoutIdle(tmoIdle), .counterTick(tick), .irq(irq));
    urxtf_peer #(.BIT(BITC)) u_urxtf_peer (
        .ref_clk(refClk), .rxLine(rxLine), .txLine(txLine), .tx_clear_input_n(tx_clear_input_n));
    initial begin
        refClk = 1'b0;
        forever #12.5 refClk = ~refClk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic results();
        $display("compares %0d errors %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic fail();
        nErrors++;
        results();
    endtask
    // one classic cycle; a read notes its expected byte
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] dv);
        int k;
        k = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= {24'h000000, dv};
        if (!we) expQ.push_back({a, 24'h000000, dv});
        do begin
            @(posedge refClk);
            k++;
        end while (wbAck !== 1'b1 && k < 40);
        if (k >= 40) fail();
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge refClk);
    endtask
    task automatic pulse(input int c);
        repeat (c) begin
            tick <= 1'b1;
            @(posedge refClk);
            tick <= 1'b0;
            @(posedge refClk);
        end
    endtask
    task automatic waitTx();
        int k;
        k = 0;
        while (txQ.size() > 0 && k < 100 * BITC) begin
            @(posedge refClk);
            k++;
        end
        if (k >= 100 * BITC) fail();
    endtask
    always @(posedge refClk) begin
        logic [39:0] x;
        logic [8:0] t;
        if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
            x = expQ.pop_front();
            `CHK($sformatf("read %h", x[39:32]), x[31:0], wbDatR)
        end
        if (u_urxtf_peer.got === 1'b1) begin
            t = txQ.pop_front();
            `CHK("tx frame", t, u_urxtf_peer.gotData)
        end
    end
    initial begin
        repeat (100000) @(posedge refClk);
        fail();
    end
    initial begin
        {resetN, wbCyc, wbStb, wbWe, tick, wbAdr, wbDatW} = '0;
        peerIdle = 1'b1;
        repeat (16) @(posedge refClk);
        resetN <= 1'b1;
        repeat (5) @(posedge refClk);
        wb(0, 8'h3C, 8'h00);
        wb(1, `URXTF_ADR_CMD, 8'h01);
        d = rnd();
        u_urxtf_peer.send(d, 1'b0);
        wb(0, `URXTF_ADR_STATUS, 8'h01);
        wb(0, `URXTF_ADR_RXQ, d);
        fork
            u_urxtf_peer.send(rnd(), 1'b0);
            begin
                repeat (4 * BITC) @(posedge refClk);
                wb(1, `URXTF_ADR_CMD, 8'h02);
            end
        join
        wb(1, `URXTF_ADR_CMD, 8'h01);
        wb(0, `URXTF_ADR_STATUS, 8'h00);
        u_urxtf_peer.send(rnd(), 1'b0);
        wb(1, `URXTF_ADR_CMD, 8'h20);
        wb(0, `URXTF_ADR_STATUS, 8'h00);
        wb(1, `URXTF_ADR_CMD, 8'h01);
        wb(1, `URXTF_ADR_OPSET, 8'h01);
        wb(1, `URXTF_ADR_CMD, 8'h81);
        `CHK("pin on", 1'b0, pinN)
        wb(1, `URXTF_ADR_CMD, 8'h91);
        `CHK("pin off", 1'b1, pinN)
        wb(1, `URXTF_ADR_MODE1, 8'h80);
        for (int i = 0; i < 9; i++) begin
            q[i] = rnd();
            if (i == 8) wb(0, `URXTF_ADR_STATUS, 8'h03);
            u_urxtf_peer.send(q[i], 1'b0);
        end
        `CHK("pin full", 1'b1, pinN)
        wb(0, `URXTF_ADR_STATUS, 8'h13);
        for (int i = 0; i < 8; i++) wb(0, `URXTF_ADR_RXQ, q[i]);
        wb(1, `URXTF_ADR_CMD, 8'h41);
        `CHK("pin again", 1'b0, pinN)
        wb(1, `URXTF_ADR_OPCLR, 8'h01);
        `CHK("pin latch", 1'b1, pinN)
        wb(1, `URXTF_ADR_MODE0, 8'h80);
        d = rnd();
        u_urxtf_peer.send(d, 1'b0);
        n = 0;
        while (irq !== 1'b1 && n < 80 * BITC) begin
            @(posedge refClk);
            n++;
        end
        `CHK("idle time", 1'b1, n > 60 * BITC && n < 66 * BITC)
        wb(0, `URXTF_ADR_ISR, 8'h10);
        wb(0, `URXTF_ADR_RXQ, d);
        wb(1, `URXTF_ADR_MODE0, 8'h00);
        wb(1, `URXTF_ADR_IMR, 8'h08);
        wb(1, `URXTF_ADR_PRE_HI, 8'h00);
        wb(1, `URXTF_ADR_PRE_LO, 8'h05);
        wb(1, `URXTF_ADR_CMD, 8'hA1);
        pulse(12);
        `CHK("held", 1'b0, irq)
        d = rnd();
        u_urxtf_peer.send(d, 1'b0);
        pulse(3);
        `CHK("early", 1'b0, irq)
        peerIdle <= 1'b0;
        pulse(9);
        `CHK("peer busy", 1'b0, irq)
        `CHK("own idle", 1'b1, tmoIdle)
        peerIdle <= 1'b1;
        pulse(1);
        `CHK("timeout", 1'b1, irq)
        wb(0, `URXTF_ADR_ISR, 8'h08);
        e = rnd();
        u_urxtf_peer.send(e, 1'b0);
        `CHK("cleared", 1'b0, irq)
        wb(0, `URXTF_ADR_RXQ, d);
        wb(0, `URXTF_ADR_RXQ, e);
        wb(1, `URXTF_ADR_CMD, 8'hC1);
        pulse(12);
        `CHK("mode off", 1'b0, irq)
        wb(1, `URXTF_ADR_CMD, 8'h02);
        wb(1, `URXTF_ADR_MODE1, 8'h18);
        u_urxtf_peer.md = 1'b1;
        u_urxtf_peer.send(rnd(), 1'b0);
        wb(0, `URXTF_ADR_STATUS, 8'h00);
        d = rnd();
        u_urxtf_peer.send(d, 1'b1);
        wb(0, `URXTF_ADR_STATUS, 8'h21);
        wb(0, `URXTF_ADR_RXQ, d);
        for (int t = 0; t < 3; t++) begin
            if (t == 2) wb(1, `URXTF_ADR_MODE2, 8'h10);
            wb(1, `URXTF_ADR_MODE1, 8'h18 | {5'h00, t[0], 2'b00});
            d = rnd();
            txQ.push_back({t[0], d});
            wb(1, `URXTF_ADR_TXQ, d);
            if (t == 2) begin
                repeat (30 * BITC) @(posedge refClk);
                `CHK("cts hold", 1'b1, txQ.size() == 1)
                u_urxtf_peer.tx_clear_input_n <= 1'b0;
            end
            waitTx();
        end
        results();
    end
endmodule
